// file: src/bfl_exec.sv
// Execution unit for shift, flag, transfer bit and memory transfer instructions
`timescale 1ns/1ps
module bfl_exec
    import bfl_pkg::*;
#(
    parameter int unsigned PM_AW    = 15,
    parameter logic [15:0] SP_RESET = SP_RESET_DEF
) (
    input  logic             CLK_IN,
    input  logic             RST_IN,
    input  logic             OP_VALID_IN,
    input  bfl_op_type       OP_CODE_IN,
    input  logic [4:0]       RD_SEL_IN,
    input  logic [2:0]       BIT_SEL_IN,
    input  logic [2:0]       FLAG_SEL_IN,
    input  bfl_ptr_sel_type  PTR_SEL_IN,
    input  bfl_ptr_mode_type PTR_MODE_IN,
    input  logic [5:0]       DISP_IN,
    input  logic [15:0]      DADDR_IN,
    output logic             READY_OUT,
    output logic             DONE_OUT,
    output logic [7:0]       FLAGS_OUT,
    output logic [15:0]      DMEM_ADDR_OUT,
    output logic [7:0]       DMEM_WDATA_OUT,
    output logic             DMEM_WE_OUT,
    output logic             DMEM_RE_OUT,
    input  logic [7:0]       DMEM_RDATA_IN,
    output logic [PM_AW-1:0] PMEM_ADDR_OUT,
    output logic             PMEM_RE_OUT,
    output logic             PMEM_WE_OUT,
    output logic [15:0]      PMEM_WDATA_OUT,
    input  logic [15:0]      PMEM_RDATA_IN,
    input  logic             PMEM_WDONE_IN,
    input  logic [5:0]       REG_ADDR_IN,
    input  logic [7:0]       REG_WDATA_IN,
    input  logic             REG_WR_IN,
    input  logic             REG_RD_IN,
    output logic [7:0]       REG_RDATA_OUT
);
    if (PM_AW < 1 || PM_AW > 15) begin : g_check
        $error("PM_AW must lie between 1 and 15");
    end

    logic [7:0]       gpr_mem [0:31];
    logic [7:0]       flags_reg;
    logic [15:0]      sp_reg;
    bfl_state_type    state_reg;
    bfl_state_type    state_next;
    logic             ready_reg;
    logic             done_reg;
    logic             done_next;
    logic [4:0]       pend_rd_reg;
    logic             pend_hi_reg;
    logic             pend_ld_reg;
    logic             pend_pm_reg;
    logic             take;
    logic             is_load;
    logic             bus_wr_gpr;
    logic [7:0]       rd_val;
    logic [4:0]       ptr_lo;
    logic [4:0]       ag_lo;
    logic [15:0]      ptr_val;
    logic [15:0]      z_val;
    logic [15:0]      ag_ptr;
    bfl_ptr_mode_type ag_mode;
    logic [15:0]      ag_addr;
    logic [15:0]      ag_ptr_new;
    logic             ag_ptr_wr;
    logic [7:0]       su_res;
    logic [7:0]       su_flags;
    logic             su_wr;

    assign take       = OP_VALID_IN && ready_reg;
    assign rd_val     = gpr_mem[RD_SEL_IN];
    assign ptr_lo     = bfl_ptr_lo(PTR_SEL_IN);
    assign ptr_val    = {gpr_mem[ptr_lo | REG_ONE], gpr_mem[ptr_lo]};
    assign z_val      = {gpr_mem[PTR_Z_LO | REG_ONE], gpr_mem[PTR_Z_LO]};
    assign is_load    = OP_CODE_IN inside {OP_LD, OP_LDS, OP_POP};
    assign bus_wr_gpr = REG_WR_IN && (REG_ADDR_IN <= REG_GPR_LAST);

    // program memory forms always address through the third pointer, only the incrementing form walks it
    always_comb begin
        ag_lo   = bfl_is_lpm(OP_CODE_IN) ? PTR_Z_LO : ptr_lo;
        ag_ptr  = bfl_is_lpm(OP_CODE_IN) ? z_val : ptr_val;
        ag_mode = PM_PLAIN;
        if (OP_CODE_IN == OP_LD || OP_CODE_IN == OP_ST) begin
            ag_mode = PTR_MODE_IN;
        end else if (OP_CODE_IN == OP_LPM_INC) begin
            ag_mode = PM_POST_INC;
        end
    end

    bfl_addr_gen u_addr_gen (
        .ptr_in     (ag_ptr),
        .mode_in    (ag_mode),
        .disp_in    (DISP_IN),
        .disp_ok_in (PTR_SEL_IN != PTR_X),
        .addr_out   (ag_addr),
        .ptr_out    (ag_ptr_new),
        .ptr_wr_out (ag_ptr_wr)
    );

    bfl_shift_unit u_shift_unit (
        .op_in       (OP_CODE_IN),
        .opnd_in     (rd_val),
        .bit_sel_in  (BIT_SEL_IN),
        .flag_sel_in (FLAG_SEL_IN),
        .flags_in    (flags_reg),
        .res_out     (su_res),
        .flags_out   (su_flags),
        .wr_reg_out  (su_wr)
    );

    always_comb begin
        state_next = state_reg;
        done_next  = 1'b0;
        unique case (state_reg)
            ST_IDLE: if (take) begin
                if (bfl_is_single(OP_CODE_IN)) begin
                    done_next = 1'b1;
                end else if (OP_CODE_IN == OP_SPM) begin
                    state_next = ST_PMW;
                end else begin
                    state_next = ST_WAIT1;
                end
            end
            ST_WAIT1: begin
                state_next = pend_pm_reg ? ST_WAIT2 : ST_IDLE;
                done_next  = !pend_pm_reg;
            end
            ST_WAIT2: begin
                state_next = ST_IDLE;
                done_next  = 1'b1;
            end
            ST_PMW: if (PMEM_WDONE_IN) begin
                state_next = ST_IDLE;
                done_next  = 1'b1;
            end
        endcase
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_reg   <= ST_IDLE;
            ready_reg   <= 1'b1;
            done_reg    <= 1'b0;
            pend_rd_reg <= REG_ZERO;
            pend_hi_reg <= 1'b0;
            pend_ld_reg <= 1'b0;
            pend_pm_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ready_reg <= (state_next == ST_IDLE);
            done_reg  <= done_next;
            if (take) begin
                pend_rd_reg <= (OP_CODE_IN == OP_LPM_R0) ? REG_ZERO : RD_SEL_IN;
                pend_hi_reg <= z_val[0];
                pend_ld_reg <= is_load;
                pend_pm_reg <= bfl_is_lpm(OP_CODE_IN);
            end
        end
    end

    // execution writes come last so they win over a colliding software write
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            for (int i = 0; i < 32; i++) begin
                gpr_mem[i] <= GPR_RESET;
            end
        end else begin
            if (bus_wr_gpr) gpr_mem[REG_ADDR_IN[4:0]] <= REG_WDATA_IN;
            if (take && su_wr) gpr_mem[RD_SEL_IN] <= su_res;
            if (take && ag_ptr_wr) begin
                gpr_mem[ag_lo]           <= ag_ptr_new[7:0];
                gpr_mem[ag_lo | REG_ONE] <= ag_ptr_new[15:8];
            end
            if (state_reg == ST_WAIT1 && pend_ld_reg) begin
                gpr_mem[pend_rd_reg] <= DMEM_RDATA_IN;
            end
            if (state_reg == ST_WAIT2) begin
                gpr_mem[pend_rd_reg] <= pend_hi_reg ? PMEM_RDATA_IN[15:8] : PMEM_RDATA_IN[7:0];
            end
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            flags_reg <= FLAGS_RESET;
        end else if (take && su_flags != flags_reg) begin
            flags_reg <= su_flags;
        end else if (REG_WR_IN && REG_ADDR_IN == REG_FLAGS) begin
            flags_reg <= REG_WDATA_IN;
        end
    end

    // stack grows down: push writes then decrements, pop increments then reads
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            sp_reg <= SP_RESET;
        end else if (take && OP_CODE_IN == OP_PUSH) begin
            sp_reg <= sp_reg - 16'h0001;
        end else if (take && OP_CODE_IN == OP_POP) begin
            sp_reg <= sp_reg + 16'h0001;
        end else if (REG_WR_IN && REG_ADDR_IN == REG_SP_LO) begin
            sp_reg[7:0] <= REG_WDATA_IN;
        end else if (REG_WR_IN && REG_ADDR_IN == REG_SP_HI) begin
            sp_reg[15:8] <= REG_WDATA_IN;
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            DMEM_ADDR_OUT  <= 16'h0000;
            DMEM_WDATA_OUT <= 8'h00;
            DMEM_WE_OUT    <= 1'b0;
            DMEM_RE_OUT    <= 1'b0;
        end else begin
            DMEM_WE_OUT <= 1'b0;
            DMEM_RE_OUT <= 1'b0;
            if (take) begin
                DMEM_WDATA_OUT <= rd_val;
                unique case (OP_CODE_IN)
                    OP_LD:   begin DMEM_ADDR_OUT <= ag_addr;  DMEM_RE_OUT <= 1'b1; end
                    OP_ST:   begin DMEM_ADDR_OUT <= ag_addr;  DMEM_WE_OUT <= 1'b1; end
                    OP_LDS:  begin DMEM_ADDR_OUT <= DADDR_IN; DMEM_RE_OUT <= 1'b1; end
                    OP_STS:  begin DMEM_ADDR_OUT <= DADDR_IN; DMEM_WE_OUT <= 1'b1; end
                    OP_PUSH: begin DMEM_ADDR_OUT <= sp_reg;   DMEM_WE_OUT <= 1'b1; end
                    OP_POP:  begin DMEM_ADDR_OUT <= sp_reg + 16'h0001; DMEM_RE_OUT <= 1'b1; end
                    default: ;
                endcase
            end
        end
    end

    // write request holds until the array answers, the core issues nothing meanwhile
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            PMEM_ADDR_OUT  <= '0;
            PMEM_RE_OUT    <= 1'b0;
            PMEM_WE_OUT    <= 1'b0;
            PMEM_WDATA_OUT <= 16'h0000;
        end else begin
            PMEM_RE_OUT <= take && bfl_is_lpm(OP_CODE_IN);
            if (take && (bfl_is_lpm(OP_CODE_IN) || OP_CODE_IN == OP_SPM)) PMEM_ADDR_OUT <= z_val[PM_AW:1];
            if (take && OP_CODE_IN == OP_SPM) begin
                PMEM_WE_OUT    <= 1'b1;
                PMEM_WDATA_OUT <= {gpr_mem[REG_ONE], gpr_mem[REG_ZERO]};
            end else if (state_reg == ST_PMW && PMEM_WDONE_IN) begin
                PMEM_WE_OUT <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            REG_RDATA_OUT <= 8'h00;
        end else if (!REG_RD_IN) begin
            REG_RDATA_OUT <= 8'h00;
        end else if (REG_ADDR_IN <= REG_GPR_LAST) begin
            REG_RDATA_OUT <= gpr_mem[REG_ADDR_IN[4:0]];
        end else begin
            unique case (REG_ADDR_IN)
                REG_SP_LO: REG_RDATA_OUT <= sp_reg[7:0];
                REG_SP_HI: REG_RDATA_OUT <= sp_reg[15:8];
                REG_FLAGS: REG_RDATA_OUT <= flags_reg;
                default:   REG_RDATA_OUT <= 8'h00;
            endcase
        end
    end

    assign READY_OUT = ready_reg;
    assign DONE_OUT  = done_reg;
    assign FLAGS_OUT = flags_reg;

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    logic [7:0] t_mask;
    assign t_mask = 8'(8'h01 << FLAG_T);

    property p_ror;
        take && OP_CODE_IN == OP_ROR |=> gpr_mem[$past(RD_SEL_IN)] == {$past(flags_reg[FLAG_C]), $past(rd_val[7:1])}
            && flags_reg[FLAG_C] == $past(rd_val[0]) && ready_reg;
    endproperty
    a_ror: assert property (p_ror) else $error("rotate right result or carry wrong");

    property p_bst;
        take && OP_CODE_IN == OP_BST |=> flags_reg[FLAG_T] == $past(rd_val[BIT_SEL_IN])
            && (flags_reg | t_mask) == ($past(flags_reg) | t_mask);
    endproperty
    a_bst: assert property (p_bst) else $error("bit store wrong or other flag touched");

    property p_bld;
        take && OP_CODE_IN == OP_BLD |=> gpr_mem[$past(RD_SEL_IN)][$past(BIT_SEL_IN)] == $past(flags_reg[FLAG_T])
            && $stable(flags_reg);
    endproperty
    a_bld: assert property (p_bld) else $error("bit load wrong or flags touched");

    property p_fset;
        take && OP_CODE_IN == OP_FSET |=> flags_reg == ($past(flags_reg) | 8'(8'h01 << $past(FLAG_SEL_IN)));
    endproperty
    a_fset: assert property (p_fset) else $error("flag set touched another flag");

    property p_ld_inc;
        take && OP_CODE_IN == OP_LD && PTR_MODE_IN == PM_POST_INC |=> DMEM_RE_OUT
            && DMEM_ADDR_OUT == $past(ptr_val) && !ready_reg ##1 ready_reg
            && {gpr_mem[$past(ptr_lo, 2) | REG_ONE], gpr_mem[$past(ptr_lo, 2)]} == 16'($past(ptr_val, 2) + 16'h0001);
    endproperty
    a_ld_inc: assert property (p_ld_inc) else $error("post-increment load address or pointer wrong");

    property p_ld_dec;
        take && OP_CODE_IN == OP_LD && PTR_MODE_IN == PM_PRE_DEC |=> DMEM_ADDR_OUT == 16'($past(ptr_val) - 16'h0001);
    endproperty
    a_ld_dec: assert property (p_ld_dec) else $error("pre-decrement load address wrong");

    property p_ld_disp;
        take && OP_CODE_IN == OP_LD && PTR_MODE_IN == PM_DISP && PTR_SEL_IN != PTR_X
            |=> DMEM_ADDR_OUT == 16'($past(ptr_val) + {10'h000, $past(DISP_IN)})
            ##1 gpr_mem[$past(RD_SEL_IN, 2)] == $past(DMEM_RDATA_IN);
    endproperty
    a_ld_disp: assert property (p_ld_disp) else $error("displacement load wrong");

    property p_st;
        take && OP_CODE_IN inside {OP_ST, OP_STS} |=> DMEM_WE_OUT && DMEM_WDATA_OUT == $past(rd_val)
            ##1 !DMEM_WE_OUT && ready_reg;
    endproperty
    a_st: assert property (p_st) else $error("store strobe or data wrong");

    property p_lds;
        take && OP_CODE_IN == OP_LDS |=> DMEM_RE_OUT && DMEM_ADDR_OUT == $past(DADDR_IN);
    endproperty
    a_lds: assert property (p_lds) else $error("direct load address wrong");

    property p_lpm;
        take && bfl_is_lpm(OP_CODE_IN) |=> !ready_reg [*2] ##1 ready_reg && done_reg;
    endproperty
    a_lpm: assert property (p_lpm) else $error("program memory read not three cycles");

    property p_push;
        take && OP_CODE_IN == OP_PUSH |=> DMEM_WE_OUT && DMEM_ADDR_OUT == $past(sp_reg)
            && sp_reg == 16'($past(sp_reg) - 16'h0001);
    endproperty
    a_push: assert property (p_push) else $error("push address or stack pointer wrong");

    property p_spm;
        state_reg == ST_PMW && !PMEM_WDONE_IN |=> !ready_reg && PMEM_WE_OUT;
    endproperty
    a_spm: assert property (p_spm) else $error("core left program write before completion");

    c_ror:  cover property (take && OP_CODE_IN == OP_ROR);
    c_lpm:  cover property (take && OP_CODE_IN == OP_LPM_INC ##3 done_reg);
    c_spm:  cover property (state_reg == ST_PMW && !PMEM_WDONE_IN ##1 PMEM_WDONE_IN);
    c_pop:  cover property (take && OP_CODE_IN == OP_POP ##2 ready_reg);
endmodule

// file: src/bfl_pkg.sv
// Shared constants, types and helpers for the bit, flag, load and store execution unit
package bfl_pkg;
    // status flag bit positions
    localparam int unsigned FLAG_C = 0;
    localparam int unsigned FLAG_Z = 1;
    localparam int unsigned FLAG_N = 2;
    localparam int unsigned FLAG_V = 3;
    localparam int unsigned FLAG_S = 4;
    localparam int unsigned FLAG_H = 5;
    localparam int unsigned FLAG_T = 6;
    localparam int unsigned FLAG_I = 7;

    localparam logic [7:0]  FLAGS_RESET  = 8'h00;
    localparam logic [7:0]  GPR_RESET    = 8'h00;
    localparam logic [15:0] SP_RESET_DEF = 16'h00ff;

    // software port map
    localparam logic [5:0]  REG_GPR_LAST = 6'h1f;
    localparam logic [5:0]  REG_SP_LO    = 6'h3d;
    localparam logic [5:0]  REG_SP_HI    = 6'h3e;
    localparam logic [5:0]  REG_FLAGS    = 6'h3f;

    // pointer pairs live in the general registers, low byte at an even index
    localparam logic [4:0]  PTR_X_LO     = 5'h1a;
    localparam logic [4:0]  PTR_Y_LO     = 5'h1c;
    localparam logic [4:0]  PTR_Z_LO     = 5'h1e;
    localparam logic [4:0]  REG_ZERO     = 5'h00;
    localparam logic [4:0]  REG_ONE      = 5'h01;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_ROR, OP_ASR, OP_SWAP, OP_FSET, OP_FCLR, OP_BST, OP_BLD,
        OP_LD, OP_ST, OP_LDS, OP_STS, OP_LPM_R0, OP_LPM, OP_LPM_INC, OP_SPM, OP_PUSH, OP_POP
    } bfl_op_type;

    typedef enum logic [1:0] {PTR_X = 2'h0, PTR_Y = 2'h1, PTR_Z = 2'h2} bfl_ptr_sel_type;
    typedef enum logic [1:0] {PM_PLAIN = 2'h0, PM_POST_INC = 2'h1, PM_PRE_DEC = 2'h2, PM_DISP = 2'h3}
        bfl_ptr_mode_type;
    typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_WAIT1 = 2'h1, ST_WAIT2 = 2'h3, ST_PMW = 2'h2} bfl_state_type;

    function automatic logic [4:0] bfl_ptr_lo(input bfl_ptr_sel_type sel);
        unique case (sel)
            PTR_X:   return PTR_X_LO;
            PTR_Y:   return PTR_Y_LO;
            default: return PTR_Z_LO;
        endcase
    endfunction

    function automatic logic bfl_is_lpm(input bfl_op_type op);
        return (op == OP_LPM_R0) || (op == OP_LPM) || (op == OP_LPM_INC);
    endfunction

    function automatic logic bfl_is_single(input bfl_op_type op);
        return !(bfl_is_lpm(op) || op inside {OP_LD, OP_ST, OP_LDS, OP_STS, OP_SPM, OP_PUSH, OP_POP});
    endfunction
endpackage

// file: src/bfl_shift_unit.sv
// Single-cycle register and flag operations: rotate, shift, swap, flag and transfer bit
`timescale 1ns/1ps
module bfl_shift_unit
    import bfl_pkg::*;
(
    input  bfl_op_type op_in,
    input  logic [7:0] opnd_in,
    input  logic [2:0] bit_sel_in,
    input  logic [2:0] flag_sel_in,
    input  logic [7:0] flags_in,
    output logic [7:0] res_out,
    output logic [7:0] flags_out,
    output logic       wr_reg_out
);
    always_comb begin
        res_out    = opnd_in;
        flags_out  = flags_in;
        wr_reg_out = 1'b0;
        unique case (op_in)
            OP_ROR: begin
                res_out           = {flags_in[FLAG_C], opnd_in[7:1]};
                flags_out[FLAG_C] = opnd_in[0];
                wr_reg_out        = 1'b1;
            end
            OP_ASR: begin
                res_out           = {opnd_in[7], opnd_in[7:1]};
                flags_out[FLAG_C] = opnd_in[0];
                wr_reg_out        = 1'b1;
            end
            OP_SWAP: begin
                res_out    = {opnd_in[3:0], opnd_in[7:4]};
                wr_reg_out = 1'b1;
            end
            OP_FSET: flags_out[flag_sel_in] = 1'b1;
            OP_FCLR: flags_out[flag_sel_in] = 1'b0;
            OP_BST:  flags_out[FLAG_T] = opnd_in[bit_sel_in];
            OP_BLD: begin
                res_out[bit_sel_in] = flags_in[FLAG_T];
                wr_reg_out          = 1'b1;
            end
            default: ;
        endcase
        // overflow follows negative xor carry, sign is left alone
        if (op_in == OP_ROR || op_in == OP_ASR) begin
            flags_out[FLAG_Z] = (res_out == 8'h00);
            flags_out[FLAG_N] = res_out[7];
            flags_out[FLAG_V] = res_out[7] ^ opnd_in[0];
        end
    end
endmodule

// file: src/bfl_addr_gen.sv
// Pointer address generation: plain, post-increment, pre-decrement and displacement
`timescale 1ns/1ps
module bfl_addr_gen
    import bfl_pkg::*;
(
    input  logic [15:0]      ptr_in,
    input  bfl_ptr_mode_type mode_in,
    input  logic [5:0]       disp_in,
    input  logic             disp_ok_in,
    output logic [15:0]      addr_out,
    output logic [15:0]      ptr_out,
    output logic             ptr_wr_out
);
    always_comb begin
        addr_out   = ptr_in;
        ptr_out    = ptr_in;
        ptr_wr_out = 1'b0;
        unique case (mode_in)
            PM_PLAIN: ;
            PM_POST_INC: begin
                ptr_out    = ptr_in + 16'h0001;
                ptr_wr_out = 1'b1;
            end
            PM_PRE_DEC: begin
                ptr_out    = ptr_in - 16'h0001;
                addr_out   = ptr_out;
                ptr_wr_out = 1'b1;
            end
            // the first pair has no displacement form, it falls back to plain
            PM_DISP: if (disp_ok_in) addr_out = ptr_in + {10'h000, disp_in};
        endcase
    end
endmodule

// file: tb/bfl_mem_model.sv
// Data and program memory model facing the execution unit
`timescale 1ns/1ps
module bfl_mem_model (
    input  wire logic [15:0] daddr_in,
    input  wire logic        clk_in,
    input  wire logic [7:0]  dwdata_in,
    input  wire logic        dwe_in,
    input  wire logic        dre_in,
    output logic      [7:0]  drdata_out,
    input  wire logic [7:0]  paddr_in,
    input  wire logic        pre_in,
    input  wire logic        pwe_in,
    input  wire logic [15:0] pwdata_in,
    output logic      [15:0] prdata_out,
    output logic             pwdone_out,
    input  wire logic [3:0]  slow_in
);
    logic [7:0]  dm [0:65535];
    logic [15:0] pm [0:255];
    logic [3:0]  cnt = 4'h0;
    initial begin
        prdata_out = 16'h0000;
        for (int i = 0; i < 65536; i++) dm[i] = 8'(i * 7 + (i >> 8));
        for (int i = 0; i < 256; i++) pm[i] = 16'(i * 291 + 19229);
    end
    // outside a read strobe the lines show inverted data so stale values cannot pass
    assign drdata_out = dre_in ? dm[daddr_in] : ~dm[daddr_in];
    assign pwdone_out = pwe_in && (cnt == slow_in);
    always @(posedge clk_in) begin
        if (dwe_in) dm[daddr_in] <= dwdata_in;
        prdata_out <= pre_in ? pm[paddr_in] : ~prdata_out;
        cnt <= (pwe_in && !pwdone_out) ? cnt + 4'h1 : 4'h0;
        if (pwdone_out) pm[paddr_in] <= pwdata_in;
    end
endmodule

// file: tb/bit_flag_load_store_exec_test.sv
// Self-checking bench comparing the execution unit with a behavioural model
`timescale 1ns/1ps
module bit_flag_load_store_exec_test;
    import bfl_pkg::*;
    logic             clk, dre, dwe, pre, pwe, wdone, rdy, done, rst = 1'b1, vld = 1'b0, wr = 1'b0, rd = 1'b0;
    bfl_op_type       op = OP_NOP;
    bfl_ptr_sel_type  psel = PTR_X;
    bfl_ptr_mode_type pmode = PM_PLAIN;
    logic [4:0]       rsel = 5'h00;
    logic [2:0]       bsel = 3'h0, fsel = 3'h0;
    logic [5:0]       disp = 6'h00, raddr = 6'h00;
    logic [15:0]      daddr = 16'h0000, dadr, pwd, prd;
    logic [7:0]       flg, dwd, drd, padr, rrd, rwd = 8'h00;
    logic [3:0]       slow = 4'h0;
    int               mr[32], mf = 0, sp = 255, fails = 0, total_checks = 0, seed = 32'h104c, cyc = 0;
    int               n, d, v, p, pv, a, q, w;
    bfl_exec #(.PM_AW(8)) dut (
        .CLK_IN(clk), .RST_IN(rst), .OP_VALID_IN(vld), .OP_CODE_IN(op), .RD_SEL_IN(rsel), .BIT_SEL_IN(bsel),
        .FLAG_SEL_IN(fsel), .PTR_SEL_IN(psel), .PTR_MODE_IN(pmode), .DISP_IN(disp), .DADDR_IN(daddr),
        .READY_OUT(rdy), .DONE_OUT(done), .FLAGS_OUT(flg), .DMEM_ADDR_OUT(dadr), .DMEM_WDATA_OUT(dwd),
        .DMEM_WE_OUT(dwe), .DMEM_RE_OUT(dre), .DMEM_RDATA_IN(drd), .PMEM_ADDR_OUT(padr), .PMEM_RE_OUT(pre),
        .PMEM_WE_OUT(pwe), .PMEM_WDATA_OUT(pwd), .PMEM_RDATA_IN(prd), .PMEM_WDONE_IN(wdone),
        .REG_ADDR_IN(raddr), .REG_WDATA_IN(rwd), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rrd));
    bfl_mem_model mem (.clk_in(clk), .daddr_in(dadr), .dwdata_in(dwd), .dwe_in(dwe), .dre_in(dre), .drdata_out(drd),
        .paddr_in(padr), .pre_in(pre), .pwe_in(pwe), .pwdata_in(pwd), .prdata_out(prd), .pwdone_out(wdone),
        .slow_in(slow));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // the whole run needs well under two thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            tally_and_finish();
        end
    end
    task automatic chk(string s, logic [15:0] e, logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr_reg(logic [5:0] ad, logic [7:0] dt);
        @(posedge clk);
        wr <= 1'b1;
        raddr <= ad;
        rwd <= dt;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(logic [5:0] ad, int e);
        @(posedge clk);
        rd <= 1'b1;
        raddr <= ad;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("register read", 16'(e & 255), {8'h00, rrd});
    endtask
    // fields other than the code and register are set by the caller beforehand
    task automatic exe(bfl_op_type o, logic [4:0] r, int lat);
        @(posedge clk);
        vld <= 1'b1;
        op <= o;
        rsel <= r;
        @(posedge clk);
        vld <= 1'b0;
        n = 1;
        #1 chk("ready after take", 16'(lat == 1), {15'h0000, rdy});
        while (done !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
            #1;
        end
        chk("cycles", 16'(lat), 16'(n));
        chk("ready at done", 16'h0001, {15'h0000, rdy});
        chk("flags", 16'(mf), {8'h00, flg});
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd_chk(REG_FLAGS, FLAGS_RESET);
        rd_chk(REG_SP_LO, 8'hff);
        rd_chk(6'h20, 8'h00);
        for (int i = 0; i < 32; i++) begin
            mr[i] = $random(seed) & 255;
            wr_reg(6'(i), 8'(mr[i]));
        end
        for (int f = 0; f < 15; f++) begin
            fsel <= 3'(f % 8);
            mf = (f < 8) ? mf | (1 << f) : mf & ~(1 << (f - 8));
            exe(f < 8 ? OP_FSET : OP_FCLR, 5'h00, 1);
        end
        $display("test flags done");
        for (int i = 0; i < 12; i++) begin
            d = $random(seed) & 15;
            v = mr[d];
            case (i % 3)
                0: mr[d] = ((mf & 1) << 7) | (v >> 1);
                1: mr[d] = (v & 128) | (v >> 1);
                default: mr[d] = ((v & 15) << 4) | (v >> 4);
            endcase
            if (i % 3 != 2) mf = (mf & 'hf0) | (v & 1) | ((mr[d] == 0) << 1) | ((mr[d] >> 7) << 2)
                | (((mr[d] >> 7) ^ (v & 1)) << 3);
            exe(i % 3 == 0 ? OP_ROR : i % 3 == 1 ? OP_ASR : OP_SWAP, 5'(d), 1);
            rd_chk(6'(d), mr[d]);
            d = $random(seed) & 15;
            bsel <= 3'(i % 8);
            mf = (mf & 'hbf) | (((mr[d] >> (i % 8)) & 1) << 6);
            exe(OP_BST, 5'(d), 1);
            d = $random(seed) & 15;
            bsel <= 3'(7 - i % 8);
            mr[d] = (mr[d] & ~(1 << (7 - i % 8))) | (((mf >> 6) & 1) << (7 - i % 8));
            exe(OP_BLD, 5'(d), 1);
        end
        $display("test shift and transfer bit done");
        for (int i = 0; i < 8; i++) begin
            p = 26 + 2 * ((i == 3) ? 1 : (i == 7) ? 2 : i % 3);
            pv = (mr[p + 1] << 8) | mr[p];
            q = $random(seed) & 63;
            d = $random(seed) & 15;
            a = (i % 4 == 3) ? (pv + q) & 'hffff : pv;
            if (i % 4 == 1) pv = (pv + 1) & 'hffff;
            if (i % 4 == 2) pv = (pv - 1) & 'hffff;
            if (i % 4 == 2) a = pv;
            mr[p] = pv & 255;
            mr[p + 1] = pv >> 8;
            psel <= bfl_ptr_sel_type'((p - 26) / 2);
            pmode <= bfl_ptr_mode_type'(i % 4);
            disp <= 6'(q);
            if (i < 4) mr[d] = mem.dm[a];
            exe(i < 4 ? OP_LD : OP_ST, 5'(d), 2);
            if (i >= 4) chk("stored byte", 16'(mr[d]), {8'h00, mem.dm[a]});
        end
        a = $random(seed) & 'hffff;
        daddr <= 16'(a);
        exe(OP_STS, 5'h03, 2);
        chk("direct store", 16'(mr[3]), {8'h00, mem.dm[a]});
        mr[5] = mr[3];
        exe(OP_LDS, 5'h05, 2);
        exe(OP_PUSH, 5'h07, 2);
        chk("pushed byte", 16'(mr[7]), {8'h00, mem.dm[sp]});
        mr[9] = mr[7];
        exe(OP_POP, 5'h09, 2);
        $display("test data transfer done");
        for (int i = 0; i < 3; i++) begin
            pv = (mr[31] << 8) | mr[30];
            w = mem.pm[(pv >> 1) & 255];
            d = (i == 0) ? 0 : 10 + i;
            mr[d] = (pv & 1) ? w >> 8 : w & 255;
            mr[30] = (i == 2) ? (pv + 1) & 255 : mr[30];
            mr[31] = (i == 2) ? ((pv + 1) >> 8) & 255 : mr[31];
            exe(bfl_op_type'(OP_LPM_R0 + i), 5'(d), 3);
        end
        for (int s = 0; s < 6; s += 5) begin
            // fresh data each pass so a lost second write cannot hide behind the first
            mr[0] = (mr[0] + s + 1) & 255;
            wr_reg(6'h00, 8'(mr[0]));
            slow <= 4'(s);
            exe(OP_SPM, 5'h00, 2 + s);
            chk("program word", 16'((mr[1] << 8) | mr[0]), mem.pm[mr[30] >> 1 | (mr[31] & 1) << 7]);
        end
        $display("test program memory done");
        for (int i = 0; i < 32; i++) rd_chk(6'(i), mr[i]);
        rd_chk(REG_SP_LO, sp);
        $display("test register dump done");
        tally_and_finish();
    end
endmodule
